// File: smi_consts.svh
// Constants for the shared-memory indirect access block.
// Assumes an APB slave that decodes word addresses (index times four).
//
// Operation
// - The block keeps a hidden staging row of five 32-bit words, the width of one memory row.
// - The staging row has no address of its own and is reached only through the data register.
// - Five data register writes fill staging bytes 0-3, 4-7, 8-11, 12-15 and 16-19 in turn.
// - A pointer write with the write bit set copies the whole staging row into the chosen row.
// - A pointer write with the read bit set and the write bit clear loads the chosen row into the staging row.
// - Five data register reads then return staging bytes 0-3 up to 16-19 in turn.
// - Every row of the memory can be written and read, with no range held back.
`ifndef SMI_CONSTS_SVH
`define SMI_CONSTS_SVH

// ----------------------------------------
// Register indices, byte address is index times four
// ----------------------------------------
`define SMI_PTR_IDX 10'h034
`define SMI_DATA_IDX 10'h035
`define SMI_STAT_IDX 10'h036

// ----------------------------------------
// Pointer fields and sizes
// ----------------------------------------
`define SMI_ROW_LSB 0
`define SMI_ROW_MSB 11
`define SMI_RD_BIT 12
`define SMI_WR_BIT 13
`define SMI_PTR_RESET 32'h00000000
`define SMI_WORDS 5
`define SMI_LAST_WORD 3'h4
`define SMI_WORD_ZERO 3'h0
`define SMI_WORD_STEP 3'h1

`endif

// File: smi_pkg.sv
// Types for the shared-memory indirect access block.
// Assumes smi_consts.svh for all numeric constants.
package smi_pkg;

    // Bus answer phase
    typedef enum logic {SMI_IDLE, SMI_ANSWER} smi_phase_type;

endpackage : smi_pkg

// File: smi_row_mem.sv
// Flip-flop row store of the shared memory.
// Assumes one clock; write is synchronous, read is combinational.
`timescale 1ns/1ps
module smi_row_mem #(
    parameter int ADDR_W = 12,
    parameter int ROW_W = 160
) (
    // Clock
    input wire logic clk,
    // Write side
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [ROW_W-1:0] wr_data,
    // Read side
    output logic [ROW_W-1:0] rd_data
);

    // Data store needs no reset; every row is reachable
    logic [ROW_W-1:0] rows [2**ADDR_W];

    assign rd_data = rows[addr];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            rows[addr] <= wr_data;
        end
    end

endmodule : smi_row_mem

// File: smi_top.sv
// APB front end of the shared-memory indirect access path.
// Assumes an APB master on pclk; every transfer has one wait state.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "smi_consts.svh"
module smi_top #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // APB answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    smi_pkg::smi_phase_type phase;
    smi_pkg::smi_phase_type next_phase;
    logic [`SMI_WORDS-1:0][31:0] row_buf;
    logic [2:0] word_idx;
    logic [31:0] pointer;
    logic [`SMI_WORDS*32-1:0] mem_rd_data;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire [9:0] word_addr = paddr[11:2];
    wire hit_ptr = word_addr == `SMI_PTR_IDX;
    wire hit_data = word_addr == `SMI_DATA_IDX;
    wire hit_stat = word_addr == `SMI_STAT_IDX;
    wire hit_any = hit_ptr | hit_data | hit_stat;
    wire access_wait = psel & penable & (phase == smi_pkg::SMI_IDLE);
    wire done = psel & penable & pready;
    wire data_done = done & hit_data;
    wire ptr_write = done & hit_ptr & pwrite;
    // Write wins if both bits are set; fetch then is skipped
    wire commit_row = ptr_write & pwdata[`SMI_WR_BIT];
    wire fetch_row = ptr_write & pwdata[`SMI_RD_BIT] & ~pwdata[`SMI_WR_BIT];
    // Only the low ADDR_W bits of the row field reach a shrunk store
    wire [ADDR_W-1:0] mem_addr = ptr_write ? pwdata[`SMI_ROW_LSB +: ADDR_W]
                                           : pointer[`SMI_ROW_LSB +: ADDR_W];
    wire at_last = word_idx == `SMI_LAST_WORD;
    wire [2:0] next_idx = at_last ? `SMI_WORD_ZERO : word_idx + `SMI_WORD_STEP;
    wire [31:0] stat_word = {29'h00000000, word_idx};
    wire [31:0] next_prdata = ~hit_any | pwrite ? 32'h00000000
                            : hit_ptr ? pointer
                            : hit_data ? row_buf[word_idx]
                            : stat_word;
    assign next_phase = access_wait ? smi_pkg::SMI_ANSWER : smi_pkg::SMI_IDLE;

    // ----------------------------------------
    // Row store
    // ----------------------------------------
    smi_row_mem #(
        .ADDR_W(ADDR_W),
        .ROW_W(`SMI_WORDS * 32)
    ) u_mem (
        .clk(pclk),
        .wr_en(commit_row),
        .addr(mem_addr),
        .wr_data(row_buf),
        .rd_data(mem_rd_data)
    );

    // ----------------------------------------
    // Bus answer, registered for clean outputs
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= smi_pkg::SMI_IDLE;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            pready <= access_wait;
            pslverr <= access_wait & ~hit_any;
            prdata <= access_wait ? next_prdata : 32'h00000000;
        end
    end

    // ----------------------------------------
    // Pointer and word index
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pointer <= `SMI_PTR_RESET;
            word_idx <= `SMI_WORD_ZERO;
        end
        else if (ptr_write)
        begin
            pointer <= pwdata;
            word_idx <= `SMI_WORD_ZERO;
        end
        else if (data_done)
        begin
            word_idx <= next_idx;
        end
    end

    // ----------------------------------------
    // Staging row, hidden behind the data register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            row_buf <= '0;
        end
        else if (fetch_row)
        begin
            row_buf <= mem_rd_data;
        end
        else if (data_done & pwrite)
        begin
            row_buf[word_idx] <= pwdata;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_idx_wraps: assert property (@(posedge pclk) disable iff (!presetn)
        data_done & at_last & ~ptr_write |=> word_idx == `SMI_WORD_ZERO)
        else $error("word index did not wrap after fifth word");

    a_idx_ptr_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ptr_write |=> word_idx == `SMI_WORD_ZERO && pointer == $past(pwdata))
        else $error("pointer write did not clear word index");

    a_idx_steps: assert property (@(posedge pclk) disable iff (!presetn)
        data_done & ~at_last |=> word_idx == $past(word_idx) + `SMI_WORD_STEP)
        else $error("word index did not step on data access");

    a_stage_write: assert property (@(posedge pclk) disable iff (!presetn)
        data_done & pwrite |=> row_buf[$past(word_idx)] == $past(pwdata))
        else $error("data write missed its staging word");

    a_data_read: assert property (@(posedge pclk) disable iff (!presetn)
        access_wait & hit_data & ~pwrite |=> pready && prdata == $past(row_buf[word_idx]))
        else $error("data read returned wrong staging word");

    a_row_commit: assert property (@(posedge pclk) disable iff (!presetn)
        commit_row |=> mem_rd_data == $past(row_buf))
        else $error("commit aimed at wrong row");

    a_row_fetch: assert property (@(posedge pclk) disable iff (!presetn)
        fetch_row |=> row_buf == $past(mem_rd_data))
        else $error("fetch did not load staging row");

    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        access_wait |=> pready ##1 !pready)
        else $error("answer not a single-cycle pulse");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        access_wait & ~hit_any |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not flagged");

    c_row_commit: cover property (@(posedge pclk) disable iff (!presetn) commit_row);
    c_row_fetch: cover property (@(posedge pclk) disable iff (!presetn) fetch_row);
    c_idx_wrap: cover property (@(posedge pclk) disable iff (!presetn) data_done & at_last);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule : smi_top

// File: smi_tb_top.sv
// Self-checking bench for the shared-memory indirect access block.
// Assumes smi_top answers APB with registered pready; rows shrunk to ADDR_W=4.
`timescale 1ns/1ps
`include "smi_consts.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
    if ((got) !== (exp)) n_errors++; end
module smi_tb_top;
    localparam logic [11:0] PTR = {`SMI_PTR_IDX, 2'b00};
    localparam logic [11:0] DAT = {`SMI_DATA_IDX, 2'b00};
    localparam logic [11:0] STA = {`SMI_STAT_IDX, 2'b00};
    localparam logic [31:0] WRB = 32'h00002000;
    localparam logic [31:0] RDB = 32'h00001000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int comparisons = 0;

    smi_top #(.ADDR_W(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #2.5 pclk = ~pclk;

    // ----------------------------------------
    // Bus access and closing
    // ----------------------------------------
    // Entered just after a rising edge; waits on pready, never a fixed count
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so the next setup never reassigns psel in this step
        @(posedge pclk);
    endtask : apb

    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        apb(1'b0, PTR, 32'h0);
        `CHK(rd, 32'h00000000)
        apb(1'b0, STA, 32'h0);
        `CHK(rd[2:0], 3'h0)
        `CHK({pready, prdata}, 33'h000000000)
    endtask : t_reset

    // Stage five words, commit, then fetch back in order
    task automatic t_row(input logic [31:0] row, input logic [31:0] base);
        for (int i = 0; i < 5; i++)
            apb(1'b1, DAT, base + i);
        apb(1'b1, PTR, WRB | row);
        apb(1'b1, PTR, RDB | row);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, DAT, 32'h0);
            `CHK(rd, base + i)
        end
    endtask : t_row

    // Index steps, wraps after five and clears on a pointer write
    task automatic t_wrap;
        for (int i = 0; i < 3; i++)
            apb(1'b1, DAT, 32'h0);
        apb(1'b0, STA, 32'h0);
        `CHK(rd[2:0], 3'h3)
        apb(1'b1, PTR, RDB | 32'h5);
        apb(1'b0, STA, 32'h0);
        `CHK(rd[2:0], 3'h0)
        for (int i = 0; i < 6; i++)
            apb(1'b0, DAT, 32'h0);
        `CHK(rd, 32'hC0DE0000)
    endtask : t_wrap

    task automatic t_misc;
        apb(1'b1, PTR, 32'hABC00000);
        apb(1'b0, PTR, 32'h0);
        `CHK(rd, 32'hABC00000)
        apb(1'b0, 12'hFFC, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h00000000)
        // Both bits set: commit only, staging row keeps the row fetched before
        apb(1'b1, PTR, WRB | RDB | 32'h3);
        apb(1'b0, DAT, 32'h0);
        `CHK(rd, 32'hC0DE0000)
        apb(1'b1, PTR, RDB | 32'h3);
        apb(1'b0, DAT, 32'h0);
        `CHK(rd, 32'hC0DE0000)
    endtask : t_misc

    // First row must survive commits to other rows
    task automatic t_kept;
        apb(1'b1, PTR, RDB);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, DAT, 32'h0);
            `CHK(rd, 32'h11110000 + i)
        end
    endtask : t_kept

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_row(32'h0, 32'h11110000);
        t_row(32'hF, 32'h22220000);
        t_row(32'h5, 32'hC0DE0000);
        t_kept();
        t_wrap();
        t_misc();
        wrap_up();
    end

    // Whole run is 63 transfers; this bound is far above it
    initial
    begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        wrap_up();
    end
endmodule : smi_tb_top
